// >>> src/wake_pkg.sv
// Purpose: Shared constants and types for the wakeup control and filter enable bank
// Assumes: Avalon-MM byte addresses, 32-bit data, one register per aligned word
// Notes: Match layout mirrors bits 7:0 and 19:16 of the filter enable register; bit 15 is not recorded
package wake_pkg;

  // Register byte offsets
  localparam logic [15:0] WAKEUP_CONTROL_OFS = 16'h5800;
  localparam logic [15:0] WAKEUP_FILTER_EN_OFS = 16'h5808;
  localparam logic [15:0] WAKE_MATCH_STATUS_OFS = 16'h5810;
  localparam logic [15:0] IRQ_STATUS_OFS = 16'h5818;
  localparam logic [15:0] IRQ_MASK_OFS = 16'h581C;

  // Wakeup control bit positions
  localparam int WUC_ADV_WAKE_BIT = 0;
  localparam int WUC_POWER_EVENT_ENABLE_ALIAS_BIT = 1;
  localparam int WUC_POWER_EVENT_STATUS_ALIAS_BIT = 2;
  localparam int WUC_SIGNAL_BIT = 3;

  // Nonvolatile configuration word bit that seeds the wakeup enable
  localparam int NV_ADV_WAKE_BIT = 10;

  // Filter enable layout
  localparam int FLT_PREDEF_LSB = 0;
  localparam int FLT_PREDEF_MSB = 7;
  localparam int FLT_IGNORE_MGMT_BIT = 15;
  localparam int FLT_FLEX_LSB = 16;
  localparam int FLT_FLEX_MSB = 19;
  localparam logic [31:0] FILTER_EN_WRITE_MASK = 32'h000F_80FF;
  localparam logic [31:0] FILTER_EN_RESET = 32'h0000_0000;

  // Widths
  localparam int MATCH_W = 12;
  localparam int IRQ_W = 2;

  // Interrupt status bits
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_APM_WAKE_BIT = 1;

  typedef struct packed {
    logic signal_on_adv_wake;
    logic power_event_status_alias;
    logic power_event_enable_alias;
    logic adv_power_wake_en;
  } wuc_s;

  typedef struct packed {
    logic [3:0] flexible;
    logic ipv6;
    logic ipv4;
    logic arp;
    logic broadcast;
    logic hashed_group;
    logic directed_unicast;
    logic wake_frame;
    logic link_change;
  } match_s;

  typedef struct packed {
    logic valid;
    logic mgmt_traffic;
    match_s hit;
  } rx_frame_s;

endpackage

// >>> src/sticky_flags.sv
// Purpose: Bank of sticky flags, set by hardware events, cleared by writing ones
// Assumes: Set, clear and wipe are synchronous to clk_i
// Notes: A set in the same cycle as a clear leaves the flag set
module sticky_flags #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic wipe_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] w1c_i,
  // State
  output logic [W-1:0] flags_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_flag
      always_ff @(posedge clk_i) begin
        if (!nrst_i || wipe_i) begin
          flags_o[g] <= 1'b0;
        end else if (set_i[g]) begin
          flags_o[g] <= 1'b1;
        end else if (w1c_i[g]) begin
          flags_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// >>> src/wakeup_regs.sv
// Purpose: Wakeup control and wakeup filter enable registers with power event logic
// Assumes: All inputs synchronous to clk_i; filter matching is done upstream
// Notes: Power event pin is open drain, driven low while pme_oe_o is high
//
// Design decision made here: the Avalon-MM interface to the registers.
module wakeup_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Power and host reset
  input wire logic lan_power_ok_i,
  input wire logic aux_power_i,
  input wire logic host_reset_n_i,
  // Nonvolatile configuration load
  input wire logic nv_load_i,
  input wire logic [15:0] nv_word_i,
  input wire logic nv_signal_on_adv_wake_i,
  // Configuration space power management side
  input wire logic cfg_power_event_enable_alias_wr_i,
  input wire logic cfg_power_event_enable_alias_i,
  input wire logic cfg_power_event_status_alias_clr_i,
  output logic power_event_enable_o,
  output logic power_event_status_o,
  // Receive match report
  input wire wake_pkg::rx_frame_s rx_frame_i,
  // Power event pin
  output logic pme_n_o,
  output logic pme_oe_o,
  // Interrupt
  output logic irq_o,
  // Avalon-MM slave
  input wire logic [15:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o
);

  // Bus state
  logic done_reg;
  logic [31:0] readdata_reg;

  // Register state
  wake_pkg::wuc_s wuc_reg;
  wake_pkg::wuc_s wuc_next;
  logic [31:0] filter_reg;
  logic [31:0] filter_next;
  logic apm_latch_reg;
  logic apm_latch_next;
  logic pme_drive_reg;
  logic irq_reg;
  logic host_reset_n_reg;
  logic [wake_pkg::IRQ_W-1:0] irq_mask_reg;

  // Bus decode
  wire logic req = read_i | write_i;
  wire logic wr_fire = write_i & done_reg;
  logic [31:0] be_mask;
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_byte_lane
      assign be_mask[gb*8 +: 8] = {8{byteenable_i[gb]}};
    end
  endgenerate
  wire logic [31:0] wr_ones = writedata_i & be_mask;
  wire logic sel_wuc = address_i == wake_pkg::WAKEUP_CONTROL_OFS;
  wire logic sel_filter = address_i == wake_pkg::WAKEUP_FILTER_EN_OFS;
  wire logic sel_match = address_i == wake_pkg::WAKE_MATCH_STATUS_OFS;
  wire logic sel_irq = address_i == wake_pkg::IRQ_STATUS_OFS;
  wire logic sel_mask = address_i == wake_pkg::IRQ_MASK_OFS;
  wire logic wr_wuc = wr_fire & sel_wuc;
  wire logic wr_filter = wr_fire & sel_filter;
  wire logic wr_match = wr_fire & sel_match;
  wire logic wr_irq = wr_fire & sel_irq;
  wire logic wr_mask = wr_fire & sel_mask;
  // Control and mask fields all live in byte lane 0
  wire logic wuc_low_wr = wr_wuc & byteenable_i[0];
  wire logic mask_low_wr = wr_mask & byteenable_i[0];

  // Clearing conditions
  wire logic host_reset_rise = host_reset_n_i & ~host_reset_n_reg;
  wire logic power_wipe = ~lan_power_ok_i;
  wire logic wake_wipe = power_wipe | (~aux_power_i & host_reset_rise);

  // Match qualification
  wire logic mgmt_blocked = rx_frame_i.mgmt_traffic &
                            filter_reg[wake_pkg::FLT_IGNORE_MGMT_BIT];
  wire logic frame_ok = rx_frame_i.valid & ~mgmt_blocked;
  wire logic [wake_pkg::MATCH_W-1:0] raw_hit = rx_frame_i.hit;
  wire logic [wake_pkg::MATCH_W-1:0] en_mask = {
    filter_reg[wake_pkg::FLT_FLEX_MSB:wake_pkg::FLT_FLEX_LSB],
    filter_reg[wake_pkg::FLT_PREDEF_MSB:wake_pkg::FLT_PREDEF_LSB]
  };
  wire logic [wake_pkg::MATCH_W-1:0] enabled_hits =
    raw_hit & en_mask & {wake_pkg::MATCH_W{frame_ok}};
  wire logic filter_wake = |enabled_hits;
  wire logic apm_wake = frame_ok & rx_frame_i.hit.wake_frame &
                        wuc_reg.adv_power_wake_en &
                        wuc_reg.signal_on_adv_wake;
  wire logic wake_event = filter_wake | apm_wake;

  // Event status clear sources
  wire logic status_w1c = wr_wuc & wr_ones[wake_pkg::WUC_POWER_EVENT_STATUS_ALIAS_BIT];
  wire logic status_clr = status_w1c | cfg_power_event_status_alias_clr_i;

  // Sticky flag instances
  logic [wake_pkg::MATCH_W-1:0] match_flags;
  logic [wake_pkg::IRQ_W-1:0] irq_flags;
  wire logic [wake_pkg::MATCH_W-1:0] match_w1c = {
    wr_ones[wake_pkg::FLT_FLEX_MSB:wake_pkg::FLT_FLEX_LSB],
    wr_ones[wake_pkg::FLT_PREDEF_MSB:wake_pkg::FLT_PREDEF_LSB]
  } & {wake_pkg::MATCH_W{wr_match}};
  wire logic [wake_pkg::IRQ_W-1:0] irq_set = {apm_wake, wake_event};
  wire logic [wake_pkg::IRQ_W-1:0] irq_w1c =
    wr_ones[wake_pkg::IRQ_W-1:0] & {wake_pkg::IRQ_W{wr_irq}};

  // Records survive host reset, only loss of LAN power wipes them
  sticky_flags #(
    .W(wake_pkg::MATCH_W)
  ) u_match_flags (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wipe_i(power_wipe),
    .set_i(enabled_hits),
    .w1c_i(match_w1c),
    .flags_o(match_flags)
  );

  sticky_flags #(
    .W(wake_pkg::IRQ_W)
  ) u_irq_flags (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wipe_i(1'b0),
    .set_i(irq_set),
    .w1c_i(irq_w1c),
    .flags_o(irq_flags)
  );

  // Wakeup control next value
  always_comb begin
    wuc_next = wuc_reg;
    apm_latch_next = apm_latch_reg;
    if (wake_wipe) begin
      wuc_next = '0;
      apm_latch_next = 1'b0;
    end else begin
      if (nv_load_i) begin
        wuc_next.adv_power_wake_en = nv_word_i[wake_pkg::NV_ADV_WAKE_BIT];
        wuc_next.signal_on_adv_wake = nv_signal_on_adv_wake_i;
      end
      if (wuc_low_wr) begin
        wuc_next.adv_power_wake_en = writedata_i[wake_pkg::WUC_ADV_WAKE_BIT];
        wuc_next.signal_on_adv_wake = writedata_i[wake_pkg::WUC_SIGNAL_BIT];
        wuc_next.power_event_enable_alias = writedata_i[wake_pkg::WUC_POWER_EVENT_ENABLE_ALIAS_BIT];
      end
      // Config space write lands after the bus write when both collide
      if (cfg_power_event_enable_alias_wr_i) begin
        wuc_next.power_event_enable_alias = cfg_power_event_enable_alias_i;
      end
      if (status_clr) begin
        wuc_next.power_event_status_alias = 1'b0;
        apm_latch_next = 1'b0;
      end
      // A wakeup in the clearing cycle must not be lost
      if (wake_event) begin
        wuc_next.power_event_status_alias = 1'b1;
      end
      if (apm_wake) begin
        apm_latch_next = 1'b1;
      end
    end
  end

  // Filter enable next value
  always_comb begin
    filter_next = filter_reg;
    if (wake_wipe) begin
      filter_next = wake_pkg::FILTER_EN_RESET;
    end else if (wr_filter) begin
      // Reserved bits are not stored, so stray ones read back as zero
      filter_next = ((filter_reg & ~be_mask) | wr_ones) &
                    wake_pkg::FILTER_EN_WRITE_MASK;
    end
  end

  // Register update
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wuc_reg <= '0;
    end else begin
      wuc_reg <= wuc_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      filter_reg <= wake_pkg::FILTER_EN_RESET;
    end else begin
      filter_reg <= filter_next;
    end
  end

  // Lets the advanced wake path drive the pin with the event enable off
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      apm_latch_reg <= 1'b0;
    end else begin
      apm_latch_reg <= apm_latch_next;
    end
  end

  // Host reset edge tracking
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      host_reset_n_reg <= 1'b1;
    end else begin
      host_reset_n_reg <= host_reset_n_i;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_mask_reg <= '0;
    end else if (mask_low_wr) begin
      irq_mask_reg <= writedata_i[wake_pkg::IRQ_W-1:0];
    end
  end

  // Pin driven only with a pending event that is allowed to signal
  wire logic pme_drive_next = wuc_next.power_event_status_alias &
    (wuc_next.power_event_enable_alias | apm_latch_next);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pme_drive_reg <= 1'b0;
    end else begin
      pme_drive_reg <= pme_drive_next;
    end
  end

  // Interrupt level lags the flags by one cycle to keep the pin glitch free
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_flags & irq_mask_reg);
    end
  end

  // Read mux
  wire logic [31:0] wuc_rd = {28'h000_0000, wuc_reg};
  wire logic [31:0] match_rd = {12'h000, match_flags[wake_pkg::MATCH_W-1:8],
                                8'h00, match_flags[7:0]};
  wire logic [31:0] irq_rd = {30'h0000_0000, irq_flags};
  wire logic [31:0] mask_rd = {30'h0000_0000, irq_mask_reg};
  wire logic [31:0] rd_value = sel_wuc ? wuc_rd :
                               sel_filter ? filter_reg :
                               sel_match ? match_rd :
                               sel_irq ? irq_rd :
                               sel_mask ? mask_rd :
                               32'h0000_0000;

  // One wait cycle per access; unmapped reads return zero, writes vanish
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= req & ~done_reg;
    end
  end

  // Captured in the wait cycle so the data stand when waitrequest drops
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      readdata_reg <= 32'h0000_0000;
    end else if (read_i && !done_reg) begin
      readdata_reg <= rd_value;
    end
  end

  assign waitrequest_o = req & ~done_reg;
  assign readdata_o = readdata_reg;
  assign power_event_enable_o = wuc_reg.power_event_enable_alias;
  assign power_event_status_o = wuc_reg.power_event_status_alias;
  assign pme_n_o = 1'b0;
  assign pme_oe_o = pme_drive_reg;
  assign irq_o = irq_reg;

endmodule

// >>> verif/wakeup_regs_properties.sv
// Purpose: Port-level checks for the wakeup register bank
// Assumes: One clock domain, synchronous active-low reset
// Notes: Register contents are judged only through the outputs
module wakeup_regs_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Stimulus side
  input wire logic lan_power_ok_i,
  input wire logic aux_power_i,
  input wire logic host_reset_n_i,
  input wire logic cfg_power_event_enable_alias_wr_i,
  input wire logic cfg_power_event_enable_alias_i,
  input wire logic cfg_power_event_status_alias_clr_i,
  input wire wake_pkg::rx_frame_s rx_frame_i,
  input wire logic read_i,
  input wire logic write_i,
  // Design outputs
  input wire logic power_event_enable_o,
  input wire logic power_event_status_o,
  input wire logic pme_oe_o,
  input wire logic irq_o,
  input wire logic waitrequest_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_wait;
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("bus wait too long");
  property p_lan;
    !lan_power_ok_i && !rx_frame_i.valid && !cfg_power_event_enable_alias_wr_i
      |=> !power_event_enable_o && !power_event_status_o && !pme_oe_o;
  endproperty
  a_lan: assert property (p_lan) else $error("power loss did not clear");
  property p_host;
    $rose(host_reset_n_i) && !aux_power_i && !rx_frame_i.valid && !cfg_power_event_enable_alias_wr_i
      |-> ##[1:2] !power_event_enable_o && !power_event_status_o;
  endproperty
  a_host: assert property (p_host) else $error("host reset did not clear");
  property p_cfg_en;
    cfg_power_event_enable_alias_wr_i && lan_power_ok_i && $stable(host_reset_n_i)
      |=> power_event_enable_o == $past(cfg_power_event_enable_alias_i);
  endproperty
  a_cfg_en: assert property (p_cfg_en) else $error("enable alias wrong");
  property p_cfg_clr;
    cfg_power_event_status_alias_clr_i && !rx_frame_i.valid |=> !power_event_status_o;
  endproperty
  a_cfg_clr: assert property (p_cfg_clr) else $error("status not cleared");
  property p_power_event_enable_alias;
    power_event_status_o && power_event_enable_o |-> pme_oe_o;
  endproperty
  a_power_event_enable_alias: assert property (p_power_event_enable_alias) else $error("event pin not driven");
  property p_pme_st;
    pme_oe_o |-> power_event_status_o;
  endproperty
  a_pme_st: assert property (p_pme_st) else $error("pin driven without status");
  property p_hold;
    power_event_status_o && !cfg_power_event_status_alias_clr_i && !write_i && lan_power_ok_i
      && $stable(host_reset_n_i) |=> power_event_status_o;
  endproperty
  a_hold: assert property (p_hold) else $error("status lost");
  property p_rise;
    $rose(power_event_status_o) |-> $past(rx_frame_i.valid);
  endproperty
  a_rise: assert property (p_rise) else $error("status set without report");
  c_adv: cover property (pme_oe_o && !power_event_enable_o);
  c_irq: cover property ($rose(irq_o));
  c_host: cover property ($rose(host_reset_n_i) && !aux_power_i);
endmodule

// >>> verif/pm_host_model.sv
// Purpose: Config-space side that writes the event enable and clears event status
// Assumes: Called right after a rising edge
// Notes: No config read path; the value line is scrambled outside a write
module pm_host_model (
  // Clock
  input wire logic clk_i,
  // Config requests
  output logic en_wr_o,
  output logic en_o,
  output logic status_clr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    en_wr_o = 1'b0;
    en_o = 1'b0;
    status_clr_o = 1'b0;
  end
  task automatic set_en(input logic v);
    en_wr_o <= 1'b1;
    en_o <= v;
    @(posedge clk_i);
    en_wr_o <= 1'b0;
    en_o <= ~v;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic clr_status();
    status_clr_o <= 1'b1;
    @(posedge clk_i);
    status_clr_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

// >>> verif/wakeup_regs_tb.sv
// Purpose: Self-checking bench for the wakeup register bank
// Assumes: The bench waits on waitrequest rather than a fixed latency
// Notes: Reads queue their expected data; a monitor compares at completion
module wakeup_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CTL = wake_pkg::WAKEUP_CONTROL_OFS;
  localparam logic [15:0] FLT = wake_pkg::WAKEUP_FILTER_EN_OFS;
  localparam logic [15:0] REC = wake_pkg::WAKE_MATCH_STATUS_OFS;
  localparam logic [15:0] ISTS = wake_pkg::IRQ_STATUS_OFS;
  localparam logic [15:0] IMSK = wake_pkg::IRQ_MASK_OFS;
  logic clk_i, nrst_i, lan_power_ok_i, aux_power_i, host_reset_n_i, nv_load_i;
  logic nv_signal_on_adv_wake_i, cfg_power_event_enable_alias_wr_i, cfg_power_event_enable_alias_i, cfg_power_event_status_alias_clr_i;
  logic power_event_enable_o, power_event_status_o, pme_n_o, pme_oe_o, irq_o;
  logic read_i, write_i, waitrequest_o;
  logic [15:0] nv_word_i, address_i;
  logic [31:0] writedata_i, readdata_o, r;
  logic [3:0] byteenable_i;
  wake_pkg::rx_frame_s rx_frame_i;
  logic [31:0] exp_q[$];
  int bad_count, compares, cycles, b;
  wakeup_regs wakeup_regs_inst (.*);
  pm_host_model pm_host_model_inst (.clk_i(clk_i), .en_wr_o(cfg_power_event_enable_alias_wr_i),
    .en_o(cfg_power_event_enable_alias_i), .status_clr_o(cfg_power_event_status_alias_clr_i));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic results();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      results();
    end
  end
  always @(posedge clk_i) begin
    if (read_i && waitrequest_o === 1'b0) begin
      chk("readdata", exp_q.pop_front(), readdata_o);
    end
  end
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic w = 1'b1);
    address_i <= a;
    writedata_i <= d;
    write_i <= w;
    read_i <= !w;
    do @(posedge clk_i); while (waitrequest_o !== 1'b0);
    write_i <= 1'b0;
    read_i <= 1'b0;
    writedata_i <= ~d;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wr(a, 32'h0000_0000, 1'b0);
  endtask
  task automatic ev(input logic [11:0] h, input logic m);
    rx_frame_i <= {1'b1, m, h};
    @(posedge clk_i);
    rx_frame_i <= {1'b0, ~m, ~h};
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    {nrst_i, nv_load_i, nv_signal_on_adv_wake_i, read_i, write_i} = '0;
    {lan_power_ok_i, aux_power_i, host_reset_n_i} = '1;
    {nv_word_i, address_i, writedata_i} = '0;
    byteenable_i = 4'hF;
    rx_frame_i = '0;
    r = $urandom(32'h8d80_3b1c);
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rd(CTL, 32'h0000_0000);
    rd(FLT, 32'h0000_0000);
    r = $urandom;
    wr(FLT, r & ~32'h0000_7F00);
    rd(FLT, r & wake_pkg::FILTER_EN_WRITE_MASK);
    wr(16'h5804, r);
    rd(16'h5804, 32'h0000_0000);
    $display("test reset_and_access done");
    wr(IMSK, 32'h0000_0001);
    for (int i = 0; i < 12; i++) begin
      b = (i < 8) ? i : i + 8;
      wr(FLT, 32'h0000_0001 << b);
      wr(CTL, 32'h0000_0002);
      ev(12'hFFF, 1'b0);
      chk("pme_oe", 1'h1, pme_oe_o);
      chk("pme_n", 1'h0, pme_n_o);
      chk("status", 1'h1, power_event_status_o);
      chk("irq", 1'h1, irq_o);
      rd(REC, 32'h0000_0001 << b);
      rd(CTL, 32'h0000_0006);
      wr(REC, 32'hFFFF_FFFF);
      wr(ISTS, 32'hFFFF_FFFF);
      wr(CTL, 32'h0000_0004);
      chk("pme_oe", 1'h0, pme_oe_o);
    end
    wr(FLT, 32'h000F_00FF);
    ev(12'hFFF, 1'b0);
    rd(REC, 32'h000F_00FF);
    wr(REC, 32'hFFFF_FFFF);
    wr(CTL, 32'h0000_0004);
    $display("test filter_bits done");
    wr(FLT, 32'h0000_8011);
    ev(12'h011, 1'b1);
    rd(REC, 32'h0000_0000);
    rd(CTL, 32'h0000_0000);
    ev(12'h011, 1'b0);
    rd(REC, 32'h0000_0011);
    chk("pme_oe", 1'h0, pme_oe_o);
    pm_host_model_inst.set_en(1'b1);
    chk("pme_oe", 1'h1, pme_oe_o);
    chk("enable", 1'h1, power_event_enable_o);
    wr(CTL, 32'h0000_0002);
    rd(CTL, 32'h0000_0006);
    pm_host_model_inst.clr_status();
    rd(CTL, 32'h0000_0002);
    chk("status", 1'h0, power_event_status_o);
    $display("test mgmt_and_alias done");
    wr(IMSK, 32'h0000_0000);
    wr(ISTS, 32'hFFFF_FFFF);
    ev(12'h010, 1'b0);
    chk("irq", 1'h0, irq_o);
    rd(ISTS, 32'h0000_0001);
    wr(IMSK, 32'h0000_0001);
    @(posedge clk_i);
    chk("irq", 1'h1, irq_o);
    wr(ISTS, 32'h0000_0001);
    @(posedge clk_i);
    chk("irq", 1'h0, irq_o);
    $display("test interrupt done");
    wr(CTL, 32'h0000_0004);
    wr(FLT, 32'h0000_0000);
    nv_word_i <= 16'($urandom) | 16'h0400;
    nv_signal_on_adv_wake_i <= 1'b1;
    nv_load_i <= 1'b1;
    @(posedge clk_i);
    nv_load_i <= 1'b0;
    @(posedge clk_i);
    rd(CTL, 32'h0000_0009);
    ev(12'h002, 1'b0);
    chk("pme_oe", 1'h1, pme_oe_o);
    rd(CTL, 32'h0000_000D);
    $display("test advanced_wake done");
    wr(FLT, 32'h0000_0010);
    lan_power_ok_i <= 1'b0;
    @(posedge clk_i);
    lan_power_ok_i <= 1'b1;
    @(posedge clk_i);
    chk("pme_oe", 1'h0, pme_oe_o);
    rd(CTL, 32'h0000_0000);
    rd(FLT, 32'h0000_0000);
    wr(FLT, 32'h0000_0001);
    wr(CTL, 32'h0000_0003);
    for (int k = 0; k < 2; k++) begin
      aux_power_i <= (k == 0);
      host_reset_n_i <= 1'b0;
      @(posedge clk_i);
      host_reset_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rd(FLT, {31'h0000_0000, k == 0});
      rd(CTL, {30'h0000_0000, {2{k == 0}}});
    end
    $display("test power_resets done");
    results();
  end
endmodule
bind wakeup_regs wakeup_regs_properties wakeup_regs_properties_inst (.*);
